// File: rtl/setting_port_cfg.svh
// constants for the strobed setting port: timing counts and codes
// assumes a 200 MHz system clock (5 ns period)
`ifndef SETTING_PORT_CFG_SVH
`define SETTING_PORT_CFG_SVH

`define CLK_MHZ              200
// strobe low phase, nominal and longest, in ns
`define STROBE_WIDTH_NS      6000
`define STROBE_WIDTH_MAX_NS  6800
`define STROBE_CYC           ((`STROBE_WIDTH_NS * `CLK_MHZ) / 1000)
// output data valid after the falling edge, longest, in ns
`define OUT_DELAY_NS         1500
`define OUT_DELAY_CYC        ((`OUT_DELAY_NS * `CLK_MHZ) / 1000)
// input sample window from the falling edge, in ns
`define SAMPLE_MIN_NS        10500
`define SAMPLE_MAX_NS        12500
`define SAMPLE_CYC           (((`SAMPLE_MIN_NS + `SAMPLE_MAX_NS) / 2 * `CLK_MHZ) / 1000)
// cycle length: sample must fall inside it
`define CYCLE_END_CYC        ((`SAMPLE_MAX_NS * `CLK_MHZ) / 1000)
// external low pulse thresholds for test mode stepping, in ns
`define NO_TM_NS             35000
`define TM_NS                50000
`define TM_CYC               ((((`NO_TM_NS + `TM_NS) / 2) * `CLK_MHZ) / 1000)
// watchdog timeout in us (between 50 and 100 ms)
`define WDOG_US              75000
`define WDOG_CYC             (`WDOG_US * `CLK_MHZ)
// configuration code that makes the port an input
`define IO_CONF_INPUT        5'h07
`define CNT_W                25

`endif

// File: rtl/setting_port_pkg.sv
// types shared by the strobed setting port files
// assumes setting_port_cfg.svh supplies the numeric constants
package setting_port_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_LOW   = 4'b0010,
      ST_HIGH  = 4'b0100,
      ST_DONE  = 4'b1000
   } strobe_state_t;
   typedef logic [1:0] test_mode_t;
endpackage

// File: rtl/pin_sync.sv
// three-stage input synchroniser with second/third agreement filter
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
module pin_sync (
   input  wire logic sys_clk,   // system clock
   input  wire logic rst_n,     // async reset, active low
   input  wire logic async_in,  // pin level
   output logic      sync_out   // filtered level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // shift chain; output moves only when stages two and three agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff    <= 1'b1;
         s2_ff    <= 1'b1;
         s3_ff    <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            sync_out <= s3_ff;
         end
      end
   end
endmodule

// File: rtl/strobed_parameter_port.sv
// strobed four-bit setting port with open-drain strobe and test mode stepping
// assumes a request pulse from the slave core, pins resolved by the bench
// and pin levels that may change at any moment against sys_clk
`timescale 1ns/1ps
`include "setting_port_cfg.svh"
module strobed_parameter_port
   import setting_port_pkg::*;
(
   input  wire logic       sys_clk,            // 200 MHz clock
   input  wire logic       rst_n,              // async reset, active low
   input  wire logic       xfer_req,           // one-cycle transfer request
   input  wire logic       data_request,       // request is a master data request
   input  wire logic [4:0] io_conf,            // stored io configuration code
   input  wire logic [3:0] setting_out,        // nibble to drive out
   input  wire logic       data_strobe_seen,   // pulse: data strobe issued elsewhere
   input  wire logic       soft_reset_req,     // pulse: soft reset from other sources
   input  wire logic [3:0] setting_port_in,    // port pin levels
   output logic      [3:0] setting_port_oe,    // drive low enable per pin
   output logic      [3:0] setting_port_out,   // driven level (always low)
   output logic            setting_pullup_en,  // weak pull-up source enable
   input  wire logic       setting_strobe_n_in,// strobe pin level
   output logic            setting_strobe_n_oe,// strobe drive low enable
   output logic            setting_strobe_n_out,// strobe driven level
   output logic [3:0]      setting_resp,       // sampled input nibble
   output logic            setting_resp_valid, // pulse: response ready
   output logic            busy,               // strobe cycle in progress
   output logic [1:0]      test_mode,          // 0 regular, 1..3 test modes
   output logic            wdog_reset          // pulse: watchdog soft reset
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   localparam logic [`CNT_W-1:0] STB_C   = `CNT_W'(`STROBE_CYC);
   // output data is loaded on the strobe's own edge, far inside its delay limit
   localparam logic [`CNT_W-1:0] SMP_C   = `CNT_W'(`SAMPLE_CYC);
   localparam logic [`CNT_W-1:0] END_C   = `CNT_W'(`CYCLE_END_CYC);
   localparam logic [`CNT_W-1:0] TM_C    = `CNT_W'(`TM_CYC);
   localparam logic [`CNT_W-1:0] WDOG_C  = `CNT_W'(`WDOG_CYC);

   // saturating increment used by the counters
   function automatic logic [`CNT_W-1:0] sat_inc(input logic [`CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + `CNT_W'(1);
   endfunction

   // true when a request turns the whole port to input
   function automatic logic input_cycle(input logic dr, input logic [4:0] conf);
      input_cycle = dr && (conf == `IO_CONF_INPUT);
   endfunction

   // ----------------------------------------------------------------
   // strobe pin input
   // ----------------------------------------------------------------
   logic strobe_lvl;
   pin_sync u_strobe_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (setting_strobe_n_in),
      .sync_out (strobe_lvl)
   );

   // ----------------------------------------------------------------
   // parameter pin inputs
   // ----------------------------------------------------------------
   // every pin gets its own filter; the sample point sits mid-window,
   // so the few cycles of filter lag still land well inside it and a
   // bit that settles late is never caught half way
   logic [3:0] port_lvl;
   pin_sync u_port_sync0 (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (setting_port_in[0]),
      .sync_out (port_lvl[0])
   );

   pin_sync u_port_sync1 (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (setting_port_in[1]),
      .sync_out (port_lvl[1])
   );

   pin_sync u_port_sync2 (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (setting_port_in[2]),
      .sync_out (port_lvl[2])
   );

   pin_sync u_port_sync3 (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (setting_port_in[3]),
      .sync_out (port_lvl[3])
   );

   // ----------------------------------------------------------------
   // strobe cycle sequencer
   // ----------------------------------------------------------------
   strobe_state_t    state_ff;
   logic [`CNT_W-1:0] cyc_cnt_ff;
   logic             dir_in_ff;      // direction latched for whole cycle
   logic             soft_pend_ff;   // soft reset strobe owed
   logic             soft_cyc_ff;    // current cycle is a soft reset strobe
   logic             wdog_fire;

   // a request and an owed soft strobe both open a cycle; the owed one wins
   wire soft_evt = soft_reset_req | wdog_fire;
   wire start    = (state_ff == ST_IDLE) && (soft_pend_ff || xfer_req);

   // remember a soft reset until the sequencer can issue its strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_pend_ff <= 1'b0;
      end else if (soft_evt) begin
         // set wins over the clear: a soft reset landing on a start is kept
         soft_pend_ff <= 1'b1;
      end else if (start) begin
         soft_pend_ff <= 1'b0;
      end
   end

   // state and cycle counter; every cycle runs to the end of the input
   // window whatever its direction, so all strobe cycles are equally long
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= ST_IDLE;
         cyc_cnt_ff <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               cyc_cnt_ff <= '0;
               if (start) begin
                  state_ff <= ST_LOW;
               end
            end
            ST_LOW: begin
               cyc_cnt_ff <= sat_inc(cyc_cnt_ff);
               if (cyc_cnt_ff == STB_C - `CNT_W'(1)) begin
                  state_ff <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               cyc_cnt_ff <= sat_inc(cyc_cnt_ff);
               if (cyc_cnt_ff == END_C) begin
                  state_ff <= ST_DONE;
               end
            end
            ST_DONE: begin
               cyc_cnt_ff <= '0;
               state_ff   <= ST_IDLE;
            end
            default: begin
               state_ff   <= ST_IDLE;
               cyc_cnt_ff <= '0;
            end
         endcase
      end
   end

   // direction chosen once at cycle start, for the whole port
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_in_ff   <= 1'b0;
         soft_cyc_ff <= 1'b0;
      end else if (start) begin
         dir_in_ff   <= !soft_pend_ff && input_cycle(data_request, io_conf);
         soft_cyc_ff <= soft_pend_ff;
      end
   end

   // strobe pin drive: low phase only
   // the pin is open-drain: only the enable moves, the driven level stays low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         setting_strobe_n_oe  <= 1'b0;
         setting_strobe_n_out <= 1'b0;
         busy                 <= 1'b0;
      end else begin
         setting_strobe_n_oe  <= start || ((state_ff == ST_LOW)
                                 && (cyc_cnt_ff < STB_C - `CNT_W'(1)));
         setting_strobe_n_out <= 1'b0;
         busy                 <= start || (state_ff == ST_LOW) || (state_ff == ST_HIGH);
      end
   end

   // ----------------------------------------------------------------
   // port data drive, pull-up and sampling
   // ----------------------------------------------------------------
   // output nibble loaded at the falling edge, held until the next one or a soft reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         setting_port_oe  <= 4'h0;
         setting_port_out <= 4'h0;
      end else if (soft_evt) begin
         setting_port_oe  <= 4'h0;
      end else if (start) begin
         if (soft_pend_ff || input_cycle(data_request, io_conf)) begin
            setting_port_oe <= 4'h0;
         end else begin
            setting_port_oe <= ~setting_out;
         end
      end
   end

   // pull-up source follows the configuration code
   // the input code hands the released lines over to the far side entirely
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         setting_pullup_en <= 1'b1;
      end else begin
         setting_pullup_en <= (io_conf != `IO_CONF_INPUT);
      end
   end

   // one sample per input cycle, mid-window
   // a soft reset strobe carries no data and never yields a response
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         setting_resp       <= 4'h0;
         setting_resp_valid <= 1'b0;
      end else begin
         setting_resp_valid <= 1'b0;
         if ((state_ff == ST_HIGH) && dir_in_ff && !soft_cyc_ff
             && (cyc_cnt_ff == SMP_C)) begin
            setting_resp       <= port_lvl;
            setting_resp_valid <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // test mode stepping from external low pulses
   // ----------------------------------------------------------------
   logic [`CNT_W-1:0] low_cnt_ff;
   logic              stepped_ff;
   // our own low phase is masked; the few cycles of filter lag after it ends
   // are far below the threshold, so they never step a mode
   wire  ext_low = !strobe_lvl && (state_ff != ST_LOW);

   // measure the externally imposed low phase, step once per pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_ff <= '0;
         stepped_ff <= 1'b0;
         test_mode  <= 2'h0;
      end else if (!ext_low) begin
         low_cnt_ff <= '0;
         stepped_ff <= 1'b0;
      end else begin
         low_cnt_ff <= sat_inc(low_cnt_ff);
         if ((low_cnt_ff == TM_C) && !stepped_ff) begin
            stepped_ff <= 1'b1;
            test_mode  <= test_mode + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // communication watchdog
   // ----------------------------------------------------------------
   logic [`CNT_W-1:0] wdog_cnt_ff;
   logic              wdog_arm_ff;
   assign wdog_fire = wdog_arm_ff && (wdog_cnt_ff == WDOG_C);

   // restart on any strobe except a soft reset strobe, fire once after silence
   // the soft strobe of a firing does not rearm, so silence gives one reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_cnt_ff <= '0;
         wdog_arm_ff <= 1'b0;
         wdog_reset  <= 1'b0;
      end else begin
         wdog_reset <= wdog_fire;
         if ((start && !soft_pend_ff) || data_strobe_seen) begin
            wdog_cnt_ff <= '0;
            wdog_arm_ff <= 1'b1;
         end else if (wdog_fire) begin
            wdog_arm_ff <= 1'b0;
            wdog_cnt_ff <= '0;
         end else if (wdog_arm_ff) begin
            wdog_cnt_ff <= sat_inc(wdog_cnt_ff);
         end
      end
   end

endmodule

// File: test/port_monitor.sv
// checker for the strobed setting port, watching the top ports only
// assumes one sys_clk domain and rst_n asynchronous, active low
`timescale 1ns/1ps
`include "setting_port_cfg.svh"
module port_monitor (
   input wire logic       sys_clk,              // clock
   input wire logic       rst_n,                // reset, active low
   input wire logic       xfer_req,             // request pulse
   input wire logic       data_request,         // data request flag
   input wire logic [4:0] io_conf,              // config code
   input wire logic [3:0] setting_out,          // nibble to drive
   input wire logic       soft_reset_req,       // soft reset pulse
   input wire logic       setting_strobe_n_in,  // strobe wire level
   input wire logic [3:0] setting_port_oe,      // pin drive enables
   input wire logic [3:0] setting_port_out,     // pin drive level
   input wire logic       setting_pullup_en,    // pull-up enable
   input wire logic       setting_strobe_n_oe,  // strobe drive enable
   input wire logic       setting_strobe_n_out, // strobe drive level
   input wire logic       setting_resp_valid,   // response pulse
   input wire logic       busy,                 // cycle running
   input wire logic [1:0] test_mode             // test mode
);
   logic [15:0] high_len_ff, since_ff, low_len_ff, soft_wait_ff;
   logic        oe_d_ff, pin_d_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // strobe drive length, time since strobe start, length of last wire low,
   // cycles spent waiting for the strobe owed after a soft reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_len_ff <= 16'h0000;
         since_ff    <= 16'h0000;
         low_len_ff  <= 16'h0000;
         soft_wait_ff <= 16'h0000;
         oe_d_ff     <= 1'b0;
         pin_d_ff    <= 1'b1;
      end else begin
         high_len_ff <= setting_strobe_n_oe ? high_len_ff + 16'h0001 : 16'h0000;
         since_ff    <= (setting_strobe_n_oe && !oe_d_ff) ? 16'h0001 : since_ff + 16'h0001;
         if (!setting_strobe_n_in)
            low_len_ff <= pin_d_ff ? 16'h0001 : low_len_ff + 16'h0001;
         if (soft_reset_req)
            soft_wait_ff <= 16'h0001;
         else if (setting_strobe_n_oe && !oe_d_ff)
            soft_wait_ff <= 16'h0000;
         else if (soft_wait_ff != 16'h0000)
            soft_wait_ff <= soft_wait_ff + 16'h0001;
         oe_d_ff     <= setting_strobe_n_oe;
         pin_d_ff    <= setting_strobe_n_in;
      end
   end
   sequence s_take;
      xfer_req && !busy && !$past(busy) && !soft_reset_req;
   endsequence
   sequence s_input;
      io_conf == `IO_CONF_INPUT && data_request;
   endsequence
   a_input_dir: assert property (
      s_take ##0 s_input |=> setting_strobe_n_oe && setting_port_oe == 4'h0)
      else $error("input cycle drives the port");
   a_output_dir: assert property (
      s_take ##0 !(io_conf == `IO_CONF_INPUT && data_request)
      |=> setting_strobe_n_oe && setting_port_oe == ~$past(setting_out))
      else $error("output nibble not driven at strobe start");
   a_strobe_width: assert property ($fell(setting_strobe_n_oe) |->
      high_len_ff >= 16'h04b0 && high_len_ff <= 16'h0550) else $error("strobe width wrong");
   a_hold_out: assert property (busy && $past(busy) && !$past(soft_reset_req) |->
      $stable(setting_port_oe)) else $error("port changed within a cycle");
   a_pins_low: assert property (setting_port_out == 4'h0 && !setting_strobe_n_out)
      else $error("open-drain level not low");
   a_pullup_off: assert property (io_conf == `IO_CONF_INPUT |=> !setting_pullup_en)
      else $error("pull-up on with input code");
   a_soft_release: assert property (soft_reset_req |=> setting_port_oe == 4'h0)
      else $error("soft reset left port driven");
   a_soft_strobe: assert property (soft_wait_ff <= 16'h0a28)
      else $error("no strobe after soft reset");
   a_resp_window: assert property (setting_resp_valid |->
      since_ff >= 16'h0834 && since_ff <= 16'h09c4) else $error("sample outside window");
   a_mode_step: assert property ($changed(test_mode) |->
      test_mode == $past(test_mode) + 2'h1) else $error("test mode skipped");
   a_mode_len: assert property ($changed(test_mode) |-> low_len_ff >= 16'h1b59)
      else $error("test mode stepped on short pulse");
endmodule

// File: test/param_circuit.sv
// far-side settings circuitry: answers input cycles, latches output nibbles
// assumes strobe_n is the resolved strobe wire and port_oe comes from the port
`timescale 1ns/1ps
module param_circuit (
   input  wire logic       sys_clk,   // clock
   input  wire logic       strobe_n,  // resolved strobe wire
   input  wire logic       in_mode,   // port set as input
   input  wire logic [3:0] nib,       // nibble to present
   input  wire logic [3:0] port_oe,   // port drive-low enables
   input  wire logic       pullup_en, // port pull-up on
   output logic      [3:0] pins,      // resolved pin levels
   output logic      [3:0] latched    // copy taken at strobe rise
);
   logic       prev_ff;
   int         cnt_ff;
   logic [3:0] last_ff, drv;
   initial begin
      prev_ff = 1'b1;
      cnt_ff = 0;
      last_ff = 4'h0;
      latched = 4'h0;
   end
   // count from the strobe fall, keep the optional latch on its rise
   always @(posedge sys_clk) begin
      prev_ff <= strobe_n;
      cnt_ff <= (prev_ff && !strobe_n) ? 1 : cnt_ff + 1;
      if (cnt_ff == 2100) last_ff <= nib;
      if (!prev_ff && strobe_n) latched <= pins;
   end
   // drive only in the window; released lines float to the inverse when no pull-up
   assign drv = !in_mode ? 4'hf : (cnt_ff >= 2100 && cnt_ff <= 2500) ? nib :
                pullup_en ? 4'hf : ~last_ff;
   assign pins = drv & ~port_oe;
endmodule

// File: test/strobed_parameter_port_test.sv
// self-checking bench for the strobed setting port
// assumes the partner model resolves the pins and the monitor is bound below
`timescale 1ns/1ps
module strobed_parameter_port_test;
   logic       sys_clk, rst_n, xfer_req, data_request, dstb, soft_reset_req, ext_low, in_mode;
   logic       pullup_en, strobe_oe, strobe_out, resp_valid, busy, strobe_wire, wdog_rst;
   logic [4:0] io_conf;
   logic [3:0] setting_out, port_in, port_oe, port_out, resp, nib, latched;
   logic [1:0] test_mode;
   logic [3:0] exp_q[$];
   int         errors, checked, seed, i;
   assign strobe_wire = !(strobe_oe || ext_low);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   strobed_parameter_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .xfer_req(xfer_req),
      .data_request(data_request), .io_conf(io_conf), .setting_out(setting_out),
      .data_strobe_seen(dstb), .soft_reset_req(soft_reset_req), .setting_port_in(port_in),
      .setting_port_oe(port_oe), .setting_port_out(port_out), .setting_pullup_en(pullup_en),
      .setting_strobe_n_in(strobe_wire), .setting_strobe_n_oe(strobe_oe),
      .setting_strobe_n_out(strobe_out), .setting_resp(resp), .setting_resp_valid(resp_valid),
      .busy(busy), .test_mode(test_mode), .wdog_reset(wdog_rst));
   param_circuit far_u (.sys_clk(sys_clk), .strobe_n(strobe_wire), .in_mode(in_mode),
      .nib(nib), .port_oe(port_oe), .pullup_en(pullup_en), .pins(port_in), .latched(latched));
   task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task results;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wait_idle;
      int k;
      for (k = 0; k < 3000 && busy !== 1'b0; k++) tick(1);
      if (busy !== 1'b0) begin
         errors++;
         results;
      end
      tick(2);
   endtask
   // one strobe cycle, with a refused request while busy
   task xfer(input logic dr, input logic [4:0] conf);
      logic inp;
      nib = 4'($random(seed));
      inp = dr && conf == 5'h07;
      {in_mode, io_conf, data_request, setting_out, xfer_req} = {inp, conf, dr, nib, 1'b1};
      tick(1);
      xfer_req = 1'b0;
      if (inp) exp_q.push_back(nib);
      tick(1);
      check("port drive", port_oe, inp ? 4'h0 : ~nib);
      check("pull-up", {3'h0, pullup_en}, {3'h0, conf != 5'h07});
      {setting_out, xfer_req} = {~nib, 1'b1};
      tick(1);
      xfer_req = 1'b0;
      tick(1197);
      check("strobe low", {3'h0, strobe_wire}, 4'h0);
      tick(160);
      check("strobe high", {3'h0, strobe_wire}, 4'h1);
      wait_idle;
      if (!inp) check("latched", latched, nib);
      check("port held", port_oe, inp ? 4'h0 : ~nib);
   endtask
   // response watcher takes the oldest noted nibble
   always @(posedge sys_clk) begin
      if (resp_valid === 1'b1) begin
         if (exp_q.size() == 0) check("spare response", resp, ~resp);
         else check("response", resp, exp_q.pop_front());
      end
      if (rst_n === 1'b1 && wdog_rst !== 1'b0)
         check("watchdog", {3'h0, wdog_rst}, 4'h0);
   end
   initial begin
      {seed, errors, checked} = {32'd93, 32'd0, 32'd0};
      {rst_n, xfer_req, data_request, dstb, soft_reset_req, ext_low, in_mode} = 7'h00;
      {io_conf, setting_out, nib} = 13'h0000;
      tick(6);
      rst_n = 1'b1;
      tick(1);
      xfer(1'b0, 5'h00);
      xfer(1'b1, 5'h07);
      xfer(1'b1, 5'h07);
      xfer(1'b0, 5'h07);
      xfer(1'b1, 5'h03);
      {soft_reset_req, dstb} = 2'b11;
      tick(1);
      {soft_reset_req, dstb} = 2'b00;
      tick(1);
      check("soft release", port_oe, 4'h0);
      tick(3000);
      check("still released", port_oe, 4'h0);
      for (i = 0; i < 5; i++) begin
         ext_low = 1'b1;
         tick(i == 0 ? 7000 : 10000);
         ext_low = 1'b0;
         tick(20);
         check("test mode", {2'h0, test_mode}, 4'(i % 4));
      end
      check("queue empty", 4'(exp_q.size()), 4'h0);
      results;
   end
endmodule
bind strobed_parameter_port port_monitor mon_u (.sys_clk(sys_clk), .rst_n(rst_n),
   .xfer_req(xfer_req), .data_request(data_request), .io_conf(io_conf),
   .setting_out(setting_out), .soft_reset_req(soft_reset_req),
   .setting_strobe_n_in(setting_strobe_n_in), .setting_port_oe(setting_port_oe),
   .setting_port_out(setting_port_out), .setting_pullup_en(setting_pullup_en),
   .setting_strobe_n_oe(setting_strobe_n_oe), .setting_strobe_n_out(setting_strobe_n_out),
   .setting_resp_valid(setting_resp_valid), .busy(busy), .test_mode(test_mode));
